//--- inc/fswp_regs.vh
// Purpose: constants for the boot-sector flash protection host controller
// Assumes: 40 MHz controller clock, 16-bit word-mode flash bus
// Notes:   command words follow the usual unlock convention for this family
`ifndef FSWP_REGS_VH
`define FSWP_REGS_VH

`define FSWP_CLK_MHZ        40
// strobe low / high, setup and glitch times, ns
`define FSWP_T_WE_LOW_NS    35
`define FSWP_T_WE_HIGH_NS   30
`define FSWP_T_SETUP_NS     25
`define FSWP_T_GLITCH_NS    5
// cycles = ceil(ns * MHz / 1000)
`define FSWP_CYC(ns)        (((ns) * `FSWP_CLK_MHZ + 999) / 1000)

`define FSWP_UNLOCK_ADDR1   21'h000555
`define FSWP_UNLOCK_ADDR2   21'h0002aa
`define FSWP_UNLOCK_DATA1   16'h00aa
`define FSWP_UNLOCK_DATA2   16'h0055
`define FSWP_CMD_PROGRAM    16'h00a0
`define FSWP_CMD_ERASE1     16'h0080
`define FSWP_CMD_SECTOR_ER  16'h0030
`define FSWP_CMD_ENTER_SEC  16'h0088
`define FSWP_CMD_EXIT_SEC1  16'h0090
`define FSWP_CMD_EXIT_SEC2  16'h0000
`define FSWP_CMD_RESET      16'h00f0

// user op codes
`define FSWP_OP_PROGRAM     3'h0
`define FSWP_OP_ERASE       3'h1
`define FSWP_OP_ENTER_SEC   3'h2
`define FSWP_OP_EXIT_SEC    3'h3
`define FSWP_OP_RESET       3'h4
`define FSWP_OP_READ        3'h5

// electronic serial number placement, word addresses
`define FSWP_ESN_BOT_BASE   21'h000000
`define FSWP_ESN_TOP_BASE   21'h1f8000
`define FSWP_ESN_WORDS      4'h8

`endif

//--- core/fswp_strobe.v
// Purpose: one timed write or read bus cycle on the flash strobes
// Assumes: start only while idle; addr and data held by caller
// Notes:   strobe widths are far above the device glitch filter
`timescale 1ns/100ps
`include "fswp_regs.vh"

module fswp_strobe #(
	parameter LOW_CYC  = `FSWP_CYC(`FSWP_T_WE_LOW_NS),
	parameter HIGH_CYC = `FSWP_CYC(`FSWP_T_WE_HIGH_NS)
) (
	input  wire        clk,      // controller clock
	input  wire        rst_n,    // async reset, active low
	input  wire        start,    // one-cycle request
	input  wire        is_read,  // 1 read cycle, 0 write cycle
	output reg         ce_n_q,   // chip select strobe
	output reg         we_n_q,   // write strobe
	output reg         oe_n_q,   // output enable strobe
	output reg         sample_q, // pulse: read data valid now
	output reg         done_q    // pulse: cycle complete
);
	reg [7:0] cnt_q;
	reg [1:0] ph_q;
	reg       rd_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_n_q   <= 1'b1;
			we_n_q   <= 1'b1;
			oe_n_q   <= 1'b1;
			sample_q <= 1'b0;
			done_q   <= 1'b0;
			cnt_q    <= 8'h00;
			ph_q     <= 2'h0;
			rd_q     <= 1'b0;
		end else begin
			sample_q <= 1'b0;
			done_q   <= 1'b0;
			case (ph_q)
			2'h0: if (start) begin
				// write needs oe high with ce and we low [RULE_20]
				rd_q   <= is_read;
				ce_n_q <= 1'b0;
				we_n_q <= is_read;
				oe_n_q <= ~is_read;
				cnt_q  <= LOW_CYC[7:0];
				ph_q   <= 2'h1;
			end
			2'h1: if (cnt_q <= 8'h01) begin
				// pulse kept well above noise width [RULE_19]
				sample_q <= rd_q;
				we_n_q   <= 1'b1;
				oe_n_q   <= 1'b1;
				ce_n_q   <= 1'b1;
				cnt_q    <= HIGH_CYC[7:0];
				ph_q     <= 2'h2;
			end else begin
				cnt_q <= cnt_q - 8'h01;
			end
			2'h2: if (cnt_q <= 8'h01) begin
				done_q <= 1'b1;
				ph_q   <= 2'h0;
			end else begin
				cnt_q <= cnt_q - 8'h01;
			end
			default: ph_q <= 2'h0;
			endcase
		end
	end
endmodule

//--- core/fswp_host.v
// Purpose: host controller issuing protected-flash command sequences
// Assumes: flash on a 16-bit word bus; pins synchronous to clk
// Notes:   device protection itself lives in the flash; host only
//          sequences commands and drives the protect pins to levels
`timescale 1ns/100ps
`include "fswp_regs.vh"

// Notes on behaviour
// RULE_01 - low write-protect pin makes device refuse both outermost boot sectors
// RULE_02 - outermost sectors: lowest two bottom-boot, highest two top-boot
// RULE_03 - high write-protect pin leaves those sectors at stored state
// RULE_04 - host always drives write-protect pin to a defined level
// RULE_05 - high voltage on reset pin enters temporary unprotect mode
// RULE_06 - temporary unprotect lets device program previously protected sectors
// RULE_07 - with write-protect low, outermost sectors stay protected even then
// RULE_08 - removing high voltage restores all earlier protection
// RULE_09 - data bit seven shows factory-locked 1 or customer-lockable 0
// RULE_10 - enter sequence maps secured region over boot sectors until exit
// RULE_11 - power-up or hardware reset maps boot addresses back to normal
// RULE_12 - factory-locked part rejects any secured region change
// RULE_13 - serial number is 16 bytes at fixed bottom or top addresses
// RULE_14 - no accelerated or bypass programming of the secured region
// RULE_15 - lock secured region: three-cycle enter then protect algorithm
// RULE_16 - a locked secured region can never be unprotected
// RULE_17 - host writes exit sequence before touching the rest of array
// RULE_18 - below lockout voltage device ignores writes and returns to read
// RULE_19 - device ignores strobe noise shorter than about 5 ns
// RULE_20 - write only with select and write low, output enable high
// RULE_21 - strobes held low at power-up give no command
// RULE_22 - program and erase only after the unlock cycles
// RULE_23 - command to a protected sector leaves its contents unchanged
module fswp_host #(
	parameter TOP_BOOT = 1'b0   // 1 top-boot device, 0 bottom-boot
) (
	input  wire        clk,          // 40 MHz clock
	input  wire        rst_n,        // async reset, active low
	input  wire        req,          // pulse: start an operation
	input  wire [2:0]  op,           // operation code
	input  wire [20:0] addr,         // word address for the operation
	input  wire [15:0] wdata,        // program data
	input  wire        wp_level,     // wanted write-protect level
	input  wire        hv_request,   // ask for high voltage on reset pin
	input  wire        esn_read,     // pulse: read one serial word
	input  wire [2:0]  esn_index,    // serial word index 0..7
	input  wire [15:0] flash_dq_i,   // data bus from flash
	output reg         busy_q,       // operation in progress
	output reg         done_q,       // pulse: operation finished
	output reg  [15:0] rdata_q,      // last read word
	output reg         sec_mapped_q, // secured region mapped now
	output reg         factory_lock_q, // indicator bit 7 of last read while mapped
	output reg         ce_n_q,       // flash chip select, active low
	output reg         oe_n_q,       // flash output enable, active low
	output reg         we_n_q,       // flash write enable, active low
	output reg  [20:0] flash_a_q,    // flash address
	output reg  [15:0] flash_dq_o_q, // data to flash
	output reg         flash_dq_oe_q,// high while host drives data
	output reg         wp_pin_q,     // write-protect pin level
	output reg         hv_en_q,      // drive high voltage on reset pin
	output reg         flash_rst_n_q // flash reset pin, active low
);
	localparam S_IDLE = 4'b0001;
	localparam S_SEQ  = 4'b0010;
	localparam S_WAIT = 4'b0100;
	localparam S_END  = 4'b1000;

	reg  [3:0]  st_q;
	reg  [2:0]  op_q;
	reg  [2:0]  step_q;
	reg  [2:0]  nsteps_q;
	reg  [20:0] a_q;
	reg  [15:0] d_q;
	reg         go_q;
	reg         cyc_rd_q;
	wire        s_ce_n;
	wire        s_we_n;
	wire        s_oe_n;
	wire        s_sample;
	wire        s_done;

	// address and data of step n of an operation
	function [36:0] seq_word;
		input [2:0]  o;
		input [2:0]  n;
		input [20:0] a;
		input [15:0] d;
		begin
			seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_RESET};
			case (n)
			// reset is one plain write; an unlock here would arm the flash
			3'h0: seq_word = (o == `FSWP_OP_RESET) ?
				{`FSWP_UNLOCK_ADDR1, `FSWP_CMD_RESET} :
				{`FSWP_UNLOCK_ADDR1, `FSWP_UNLOCK_DATA1};
			3'h1: seq_word = {`FSWP_UNLOCK_ADDR2, `FSWP_UNLOCK_DATA2};
			3'h2: case (o)
				`FSWP_OP_PROGRAM:
					seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_PROGRAM};
				`FSWP_OP_ERASE:
					seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_ERASE1};
				`FSWP_OP_ENTER_SEC:
					seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_ENTER_SEC};
				default:
					seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_EXIT_SEC1};
				endcase
			3'h3: case (o)
				`FSWP_OP_PROGRAM: seq_word = {a, d};
				`FSWP_OP_EXIT_SEC:
					seq_word = {21'h000000, `FSWP_CMD_EXIT_SEC2};
				default:
					seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_UNLOCK_DATA1};
				endcase
			3'h4: seq_word = {`FSWP_UNLOCK_ADDR2, `FSWP_UNLOCK_DATA2};
			3'h5: seq_word = {a, `FSWP_CMD_SECTOR_ER};
			default: seq_word = {`FSWP_UNLOCK_ADDR1, `FSWP_CMD_RESET};
			endcase
		end
	endfunction

	// number of bus cycles of an operation
	function [2:0] seq_len;
		input [2:0] o;
		begin
			case (o)
			`FSWP_OP_PROGRAM:   seq_len = 3'h4;
			`FSWP_OP_ERASE:     seq_len = 3'h6;
			`FSWP_OP_ENTER_SEC: seq_len = 3'h3;  // [RULE_15]
			`FSWP_OP_EXIT_SEC:  seq_len = 3'h4;
			default:            seq_len = 3'h1;
			endcase
		end
	endfunction

	fswp_strobe u_strobe (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (go_q),
		.is_read  (cyc_rd_q),
		.ce_n_q   (s_ce_n),
		.we_n_q   (s_we_n),
		.oe_n_q   (s_oe_n),
		.sample_q (s_sample),
		.done_q   (s_done)
	);

	// -----------------------------------------------------------------
	// pin levels
	// -----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_pin_q      <= 1'b0;   // defined level from reset [RULE_04]
			hv_en_q       <= 1'b0;
			flash_rst_n_q <= 1'b0;
			ce_n_q        <= 1'b1;
			oe_n_q        <= 1'b1;
			we_n_q        <= 1'b1;
		end else begin
			wp_pin_q      <= wp_level;             // [RULE_04]
			// hv only between operations; drop restores protect [RULE_05]
			if (!busy_q)
				hv_en_q <= hv_request;           // [RULE_08]
			flash_rst_n_q <= 1'b1;
			ce_n_q        <= s_ce_n;
			oe_n_q        <= s_oe_n;
			we_n_q        <= s_we_n;
		end
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q           <= S_IDLE;
			op_q           <= 3'h0;
			step_q         <= 3'h0;
			nsteps_q       <= 3'h0;
			a_q            <= 21'h000000;
			d_q            <= 16'h0000;
			go_q           <= 1'b0;
			cyc_rd_q       <= 1'b0;
			busy_q         <= 1'b0;
			done_q         <= 1'b0;
			rdata_q        <= 16'h0000;
			sec_mapped_q   <= 1'b0;  // device comes up unmapped [RULE_11]
			factory_lock_q <= 1'b0;
			flash_a_q      <= 21'h000000;
			flash_dq_o_q   <= 16'h0000;
			flash_dq_oe_q  <= 1'b0;
		end else begin
			go_q   <= 1'b0;
			done_q <= 1'b0;
			case (st_q)
			S_IDLE: if (flash_rst_n_q && (req || esn_read)) begin
				// first request waits for reset pin release [RULE_21]
				busy_q <= 1'b1;
				step_q <= 3'h0;
				st_q   <= S_SEQ;
				if (esn_read) begin
					op_q     <= `FSWP_OP_READ;
					nsteps_q <= 3'h1;
					d_q      <= 16'h0000;
					a_q      <= (TOP_BOOT ? `FSWP_ESN_TOP_BASE
					             : `FSWP_ESN_BOT_BASE)
					            + {18'h00000, esn_index}; // [RULE_13]
				end else begin
					op_q     <= op;
					// every program/erase starts with unlock cycles [RULE_22]
					nsteps_q <= seq_len(op);
					a_q      <= addr;
					d_q      <= wdata;
				end
			end
			S_SEQ: begin
				cyc_rd_q <= (op_q == `FSWP_OP_READ);
				if (op_q == `FSWP_OP_READ) begin
					flash_a_q     <= a_q;
					flash_dq_oe_q <= 1'b0;
				end else begin
					// plain unlock sequence; no bypass in region [RULE_14]
					{flash_a_q, flash_dq_o_q} <=
						seq_word(op_q, step_q, a_q, d_q);
					flash_dq_oe_q <= 1'b1;
				end
				go_q <= 1'b1;
				st_q <= S_WAIT;
			end
			S_WAIT: begin
				if (s_sample)
					rdata_q <= flash_dq_i;
				if (s_done) begin
					if (step_q + 3'h1 >= nsteps_q)
						st_q <= S_END;
					else begin
						step_q <= step_q + 3'h1;
						st_q   <= S_SEQ;
					end
				end
			end
			S_END: begin
				flash_dq_oe_q <= 1'b0;
				busy_q        <= 1'b0;
				done_q        <= 1'b1;
				st_q          <= S_IDLE;
				case (op_q)
				`FSWP_OP_ENTER_SEC: sec_mapped_q <= 1'b1;  // [RULE_10]
				// exit before touching rest of array [RULE_17]
				`FSWP_OP_EXIT_SEC:  sec_mapped_q <= 1'b0;
				`FSWP_OP_RESET:     sec_mapped_q <= sec_mapped_q;
				`FSWP_OP_READ:
					if (sec_mapped_q)
						factory_lock_q <= rdata_q[7]; // [RULE_09]
				default:            sec_mapped_q <= sec_mapped_q;
				endcase
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

//--- verif/fswp_host_asserts.sv
// Purpose: pin protocol checks for the flash host
// Assumes: two-clock strobe phases
// Notes:   bound to every fswp_host
`timescale 1ns/100ps
module fswp_host_asserts (
	input logic        clk,           // clock
	input logic        rst_n,         // reset
	input logic        req,           // request
	input logic        wp_level,      // wanted wp
	input logic        busy_q,        // busy
	input logic        done_q,        // done
	input logic        ce_n_q,        // select
	input logic        oe_n_q,        // read strobe
	input logic        we_n_q,        // write strobe
	input logic [20:0] flash_a_q,     // address
	input logic [15:0] flash_dq_o_q,  // data out
	input logic        flash_dq_oe_q, // data drive
	input logic        wp_pin_q,      // wp pin
	input logic        hv_en_q,       // hv drive
	input logic        flash_rst_n_q  // flash reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_we_ok; !we_n_q |-> !ce_n_q && oe_n_q; endproperty
	a_we_ok: assert property (p_we_ok)
		else $error("write strobe unqualified");
	property p_oe_ok; !oe_n_q |-> we_n_q && !flash_dq_oe_q; endproperty
	a_oe_ok: assert property (p_oe_ok)
		else $error("read during write");
	property p_we_len; $fell(we_n_q) |=> !we_n_q; endproperty
	a_we_len: assert property (p_we_len)
		else $error("short write pulse");
	property p_hold;
		!we_n_q ##1 !we_n_q |-> $stable(flash_a_q) && $stable(flash_dq_o_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("bus moved in write");
	property p_wp_hi; wp_level [*3] |-> wp_pin_q; endproperty
	a_wp_hi: assert property (p_wp_hi)
		else $error("wp pin not high");
	property p_wp_lo; !wp_level [*3] |-> !wp_pin_q; endproperty
	a_wp_lo: assert property (p_wp_lo)
		else $error("wp pin not low");
	property p_pwr; !flash_rst_n_q |-> ce_n_q && we_n_q; endproperty
	a_pwr: assert property (p_pwr)
		else $error("strobe in reset");
	property p_done; req && !busy_q && flash_rst_n_q |-> ##[1:80] done_q;
	endproperty
	a_done: assert property (p_done)
		else $error("no done");
	property p_hv; busy_q ##1 busy_q |-> $stable(hv_en_q); endproperty
	a_hv: assert property (p_hv)
		else $error("hv moved while busy");
endmodule
bind fswp_host fswp_host_asserts i_chk (.clk(clk), .rst_n(rst_n),
	.req(req), .wp_level(wp_level), .busy_q(busy_q), .done_q(done_q),
	.ce_n_q(ce_n_q), .oe_n_q(oe_n_q), .we_n_q(we_n_q),
	.flash_a_q(flash_a_q), .flash_dq_o_q(flash_dq_o_q),
	.flash_dq_oe_q(flash_dq_oe_q), .wp_pin_q(wp_pin_q),
	.hv_en_q(hv_en_q), .flash_rst_n_q(flash_rst_n_q));

//--- verif/fswp_flash_model.sv
// Purpose: behavioural boot-sector flash
// Assumes: word mode, untimed
// Notes:   erase clears a 4K-word span only
`timescale 1ns/100ps
module fswp_flash_model #(
	parameter TOP_BOOT = 1'b0, // top-boot part
	parameter FACTORY  = 1'b1  // factory-locked part
) (
	input  logic        ce_n,  // select
	input  logic        oe_n,  // read strobe
	input  logic        we_n,  // write strobe
	input  logic [20:0] a,     // address
	input  logic [15:0] dq_i,  // bus in
	input  logic        wp_n,  // wp pin
	input  logic        hv,    // high voltage on reset pin
	input  logic        rpin_n, // reset pin
	output logic [15:0] dq_o   // bus out
);
	logic [15:0] mem [int];
	logic [2:0]  st = 0;
	logic        sec = 0;
	logic [7:0]  d;
	int          wcnt = 0;
	// one block keeps stored protection, lifted only by high voltage
	function automatic logic lk(logic [20:0] x);
		return (!wp_n && x[20:13] == {8{TOP_BOOT}})
			|| (sec && FACTORY)
			|| (x[20:12] == 9'h030 && !hv);
	endfunction
	function automatic logic [15:0] rd(logic [20:0] x);
		if (sec && x[20:3] == (TOP_BOOT ? 18'h3f000 : 18'h0))
			return {5'h15, x[2:0], FACTORY, 7'h2b};
		return mem.exists(x) ? mem[x] : 16'hffff;
	endfunction
	// released bus shows the inverse, never a held value
	assign dq_o = (!ce_n && !oe_n) ? rd(a) : ~rd(a);
	// select and write strobe may rise in one step; take the first rise
	wire wact = !ce_n && !we_n && oe_n;
	always @(negedge wact or negedge rpin_n) begin
		d = dq_i[7:0];
		if (!rpin_n) begin
			st = 0; // back to read mode
			sec = 0;
		end else if (rpin_n) begin
			wcnt++;
			if (d == 8'hf0 && st != 3'd3) st = 0;
			else case (st)
			3'd0: st = (a == 21'h555 && d == 8'haa) ? 3'd1 : 3'd0;
			3'd1: st = (a == 21'h2aa && d == 8'h55) ? 3'd2 : 3'd0;
			3'd2: begin // no bypass entry
				st = d == 8'ha0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
				if (d == 8'h90) st = 3'd6;
				if (d == 8'h88) sec = 1;
			end
			3'd3: begin
				if (!lk(a)) mem[a] = rd(a) & dq_i;
				st = 0;
			end
			3'd4: st = d == 8'haa ? 3'd5 : 3'd0;
			3'd5: st = d == 8'h55 ? 3'd7 : 3'd0;
			3'd7: begin
				if (d == 8'h30 && !lk(a))
					foreach (mem[k]) if (k[20:12] == a[20:12]) mem[k] = 16'hffff;
				st = 0;
			end
			default: begin
				if (d == 8'h00) sec = 0;
				st = 0;
			end
			endcase
		end
	end
endmodule

//--- verif/fswp_host_test.sv
// Purpose: self-checking bench for the flash host
// Assumes: bottom-boot factory-locked and top-boot customer-lockable flash models
// Notes:   inputs move on the falling edge
`timescale 1ns/100ps
module fswp_host_test;
	logic        clk, rst_n, req, wp_level, hv_request, esn_read;
	logic [2:0]  op, esn_index;
	logic [20:0] addr, fa;
	logic [15:0] wdata, dqo, fdq, bus, rdata;
	logic        busy, done, sec_m, flk, ce_n, oe_n, we_n, dq_oe, wp, hv, frn;
	logic [20:0] fa_t;
	logic [15:0] dqo_t, fdq_t, bus_t, rdata_t;
	logic        done_t, sec_t, flk_t, ce_n_t, oe_n_t, we_n_t, dqoe_t;
	logic        wp_t, hv_t, fr_n_t;
	int          num_errors = 0, checked = 0, n, w0;
	fswp_host i_dut (.clk(clk), .rst_n(rst_n), .req(req), .op(op),
		.addr(addr), .wdata(wdata), .wp_level(wp_level),
		.hv_request(hv_request), .esn_read(esn_read),
		.esn_index(esn_index), .flash_dq_i(bus), .busy_q(busy),
		.done_q(done), .rdata_q(rdata), .sec_mapped_q(sec_m),
		.factory_lock_q(flk), .ce_n_q(ce_n), .oe_n_q(oe_n), .we_n_q(we_n),
		.flash_a_q(fa), .flash_dq_o_q(dqo), .flash_dq_oe_q(dq_oe),
		.wp_pin_q(wp), .hv_en_q(hv), .flash_rst_n_q(frn));
	fswp_flash_model i_fl (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(fa),
		.dq_i(bus), .wp_n(wp), .hv(hv), .rpin_n(frn), .dq_o(fdq));
	assign bus = dq_oe ? dqo : fdq;
	// top-boot, customer-lockable pair runs on the same stimulus
	fswp_host #(.TOP_BOOT(1'b1)) i_dut_top (.clk(clk), .rst_n(rst_n),
		.req(req), .op(op), .addr(addr), .wdata(wdata),
		.wp_level(wp_level), .hv_request(hv_request),
		.esn_read(esn_read), .esn_index(esn_index), .flash_dq_i(bus_t),
		.busy_q(), .done_q(done_t), .rdata_q(rdata_t),
		.sec_mapped_q(sec_t), .factory_lock_q(flk_t), .ce_n_q(ce_n_t),
		.oe_n_q(oe_n_t), .we_n_q(we_n_t), .flash_a_q(fa_t),
		.flash_dq_o_q(dqo_t), .flash_dq_oe_q(dqoe_t), .wp_pin_q(wp_t),
		.hv_en_q(hv_t), .flash_rst_n_q(fr_n_t));
	fswp_flash_model #(.TOP_BOOT(1'b1), .FACTORY(1'b0)) i_fl_top (
		.ce_n(ce_n_t), .oe_n(oe_n_t), .we_n(we_n_t), .a(fa_t),
		.dq_i(bus_t), .wp_n(wp_t), .hv(hv_t), .rpin_n(fr_n_t),
		.dq_o(fdq_t));
	assign bus_t = dqoe_t ? dqo_t : fdq_t;
	always #12.5 clk = ~clk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(logic [15:0] g, logic [15:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic go(logic e, logic [2:0] o, logic [20:0] a, logic [15:0] d);
		@(negedge clk);
		req = !e;
		esn_read = e;
		op = o;
		addr = a;
		wdata = d;
		esn_index = a[2:0];
		@(negedge clk);
		req = 0;
		esn_read = 0;
		for (n = 0; done !== 1'b1 && n < 200; n++) @(negedge clk);
		chk(16'(n < 200), 16'h1);
		chk(16'(done_t), 16'h1);
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_ops();
		w0 = i_fl.wcnt;
		go(0, 3'h0, 21'h012345, 16'h1234);
		chk(i_fl.rd(21'h012345), 16'h1234);
		go(0, 3'h1, 21'h012000, 16'h0);
		chk(i_fl.rd(21'h012345), 16'hffff);
		go(0, 3'h4, 21'h0, 16'h0);
		go(0, 3'h5, 21'h0, 16'h0);
		// op 5 from req is a one-word read, so no write is counted
		chk(16'(i_fl.wcnt - w0), 16'hb);
	endtask
	task automatic t_wp();
		wp_level = 0;
		go(0, 3'h0, 21'h001010, 16'h0);
		chk(i_fl.rd(21'h001010), 16'hffff);
		go(0, 3'h0, 21'h002010, 16'h0);
		chk(i_fl.rd(21'h002010), 16'h0);
		go(0, 3'h0, 21'h1ff010, 16'h0);
		chk(i_fl_top.rd(21'h1ff010), 16'hffff);
		chk(i_fl.rd(21'h1ff010), 16'h0);
		wp_level = 1;
		go(0, 3'h0, 21'h001010, 16'h0);
		chk(i_fl.rd(21'h001010), 16'h0);
	endtask
	task automatic t_busy();
		w0 = i_fl.wcnt;
		fork
			go(0, 3'h0, 21'h030000, 16'h1111);
			begin
				repeat (4) @(negedge clk);
				req = 1;
				hv_request = 1;
				@(negedge clk);
				req = 0;
				chk(16'(hv), 16'h0);
			end
		join
		chk(16'(i_fl.wcnt - w0), 16'h4);
		chk(i_fl.rd(21'h030000), 16'hffff);
		repeat (3) @(negedge clk);
		chk(16'(hv), 16'h1);
		wp_level = 0;
		go(0, 3'h0, 21'h030000, 16'h1111);
		chk(i_fl.rd(21'h030000), 16'h1111);
		go(0, 3'h0, 21'h001020, 16'h0);
		chk(i_fl.rd(21'h001020), 16'hffff);
		wp_level = 1;
		hv_request = 0;
		repeat (3) @(negedge clk);
		chk(16'(hv), 16'h0);
		go(0, 3'h0, 21'h030010, 16'h0);
		chk(i_fl.rd(21'h030010), 16'hffff);
	endtask
	task automatic t_rst();
		go(0, 3'h2, 21'h0, 16'h0);
		@(negedge clk);
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		chk(16'(sec_m), 16'h0);
		chk(16'(sec_t), 16'h0);
		repeat (2) @(negedge clk);
		go(1, 3'h0, 21'h3, 16'h0);
		chk(rdata, 16'hffff);
		chk(rdata_t, 16'hffff);
	endtask
	task automatic t_sec();
		go(0, 3'h2, 21'h0, 16'h0);
		chk(16'(sec_m), 16'h1);
		chk(16'(sec_t), 16'h1);
		for (int i = 0; i < 8; i++) begin
			go(1, 3'h0, 21'(i), 16'h0);
			chk(rdata, {5'h15, 3'(i), 1'b1, 7'h2b});
			chk(rdata_t, {5'h15, 3'(i), 1'b0, 7'h2b});
		end
		chk(16'(flk), 16'h1);
		chk(16'(flk_t), 16'h0);
		go(0, 3'h0, 21'h000020, 16'h0);
		go(0, 3'h3, 21'h0, 16'h0);
		chk(16'(sec_m), 16'h0);
		chk(i_fl.rd(21'h000020), 16'hffff);
		go(1, 3'h0, 21'h3, 16'h0);
		chk(rdata, 16'hffff);
		chk(rdata_t, 16'hffff);
	endtask
	initial begin
		{clk, rst_n, req, hv_request, esn_read} = 0;
		wp_level = 1;
		{op, esn_index, addr, wdata} = 0;
		repeat (12) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		t_ops();
		t_wp();
		t_busy();
		t_sec();
		t_rst();
		stop_test();
	end
	// run needs some 580 cycles; allow far more
	initial begin
		#400000;
		num_errors++;
		stop_test();
	end
endmodule
